// file: rtl/cccd_pkg.sv
// Shared constants for the call, clear and decrement execution unit.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
package cccd_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register byte offsets.
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_PC = 8'h08;
	localparam logic [7:0] OFS_PC_HIGH_LATCH = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_BANK = 8'h14;
	localparam logic [7:0] OFS_FADDR = 8'h18;
	localparam logic [7:0] OFS_FDATA = 8'h1c;
	localparam logic [7:0] OFS_RETURN_STACK_TOP = 8'h20;
	localparam logic [7:0] OFS_STKPTR = 8'h24;

	// Status field positions.
	localparam int STAT_Z = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_SKIP = 2;
	localparam int STAT_ILLEGAL = 3;

	// Instruction word layout.
	localparam int INSTR_W = 14;
	localparam int OP_MSB = 13;
	localparam int OP_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam int FILE_AW = 7;
	localparam int PC_W = 15;
	localparam int PC_HIGH_LATCH_W = 7;

	localparam logic [5:0] OP_CALL_ACC = 6'h00;
	localparam logic [5:0] OP_ZERO = 6'h01;
	localparam logic [5:0] OP_DEC = 6'h03;
	localparam logic [5:0] OP_INVERT = 6'h09;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0b;

	// Reset values and timing.
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam int CYC_DIV_DEFAULT = 4;
	localparam int STACK_DEPTH_DEFAULT = 16;
	localparam int BANKS_DEFAULT = 4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SECOND = 3'b100
	} cccd_state_t;
endpackage

// file: rtl/cccd_exec_if.sv
// Operand and result bundle between the sequencer and the execution datapath.
// Assumes both ends run on the same clock; the datapath is purely combinational.
`timescale 1ns/1ns
interface cccd_exec_if;
	logic [13:0] instr;
	logic [7:0] acc;
	logic [7:0] fval;
	logic [14:0] pc;
	logic [6:0] pc_high_latch;
	logic [7:0] result;
	logic write_acc;
	logic write_file;
	logic z_update;
	logic z_value;
	logic push;
	logic [14:0] ret_addr;
	logic [14:0] pc_next;
	logic two_cycle;
	logic skip;
	logic illegal;

	modport core (
		output instr, acc, fval, pc, pc_high_latch,
		input result, write_acc, write_file, z_update, z_value, push, ret_addr,
		input pc_next, two_cycle, skip, illegal
	);
	modport alu (
		input instr, acc, fval, pc, pc_high_latch,
		output result, write_acc, write_file, z_update, z_value, push, ret_addr,
		output pc_next, two_cycle, skip, illegal
	);
endinterface

// file: rtl/cccd_alu.sv
// Combinational execution datapath for the call, invert, zero and decrement group.
// Assumes the sequencer supplies the fetched file value for the decoded address.
`timescale 1ns/1ns
module cccd_alu (
	cccd_exec_if.alu x
);
	import cccd_pkg::*;

	logic [5:0] op;
	logic to_file;

	assign op = x.instr[OP_MSB:OP_LSB];
	assign to_file = x.instr[DEST_BIT];

	always_comb
	begin
		x.result = 8'h00;
		x.write_acc = 1'b0;
		x.write_file = 1'b0;
		x.z_update = 1'b0;
		x.z_value = 1'b0;
		x.push = 1'b0;
		x.ret_addr = 15'(x.pc + 15'h0001);
		x.pc_next = 15'(x.pc + 15'h0001);
		x.two_cycle = 1'b0;
		x.skip = 1'b0;
		x.illegal = 1'b0;
		case (op)
			OP_CALL_ACC:
			begin
				x.push = 1'b1;
				x.pc_next = {x.pc_high_latch, x.acc};
				x.two_cycle = 1'b1;
			end
			OP_ZERO:
			begin
				x.result = 8'h00;
				x.write_file = to_file;
				x.write_acc = !to_file;
				x.z_update = 1'b1;
				x.z_value = 1'b1;
			end
			OP_INVERT:
			begin
				x.result = ~x.fval;
				x.write_file = to_file;
				x.write_acc = !to_file;
				x.z_update = 1'b1;
				x.z_value = (~x.fval == 8'h00);
			end
			OP_DEC:
			begin
				x.result = 8'(x.fval - 8'h01);
				x.write_file = to_file;
				x.write_acc = !to_file;
				x.z_update = 1'b1;
				x.z_value = (x.fval == 8'h01);
			end
			OP_DEC_SKIP:
			begin
				x.result = 8'(x.fval - 8'h01);
				x.write_file = to_file;
				x.write_acc = !to_file;
				x.skip = (x.fval == 8'h01);
				x.two_cycle = (x.fval == 8'h01);
			end
			default:
			begin
				x.illegal = 1'b1;
			end
		endcase
	end
endmodule

// file: rtl/cccd_core.sv
// Execution unit for the call-through-accumulator, invert, zero and decrement group.
// Assumes an AXI4-Lite master, one 50 MHz clock and a synchronous active-low reset.
//
// Summary of operation
// - Call through accumulator pushes the next address onto the return stack first.
// - That call loads PC low byte from accumulator, bits 14..8 from the latch.
// - That call takes two instruction cycles and leaves every flag alone.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Invert delivers the bitwise complement of the file register.
// - Decrement delivers the file register value minus one.
// - Zeroing a file register writes zero and sets the zero flag.
// - Zeroing the accumulator writes zero and sets the zero flag.
// - Decrement-skip keeps flags; a zero result replaces the next instruction with a NOP.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module cccd_core #(
	parameter int CYC_DIV = cccd_pkg::CYC_DIV_DEFAULT,
	parameter int STACK_DEPTH = cccd_pkg::STACK_DEPTH_DEFAULT,
	parameter int BANKS = cccd_pkg::BANKS_DEFAULT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [cccd_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [cccd_pkg::AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [cccd_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [cccd_pkg::AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import cccd_pkg::*;

	localparam int DIV_W = $clog2(CYC_DIV + 1);
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam int BANK_W = (BANKS > 1) ? $clog2(BANKS) : 1;
	localparam int MEM_AW = BANK_W + FILE_AW;
	localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(CYC_DIV - 1);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		cccd_state_t state;
		logic [DIV_W-1:0] div;
		logic [13:0] instr;
		logic [7:0] acc;
		logic [14:0] pc;
		logic [6:0] pc_high_latch;
		logic z;
		logic skip;
		logic illegal;
		logic [BANK_W-1:0] bank;
		logic [6:0] faddr;
		logic [SP_W-1:0] sp;
		logic [STACK_DEPTH-1:0][14:0] stack;
		logic [(1 << MEM_AW)-1:0][7:0] mem;
	} cccd_regs_t;

	cccd_regs_t s_reg;
	cccd_regs_t s_next;
	cccd_exec_if x ();

	// Byte-lane merge used by every writable register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_STKPTR);
	endfunction

	logic tick;
	logic [MEM_AW-1:0] cur_faddr;
	logic [MEM_AW-1:0] exe_faddr;
	logic [SP_W-1:0] sp_top;

	assign tick = (s_reg.div == '0);
	assign cur_faddr = {s_reg.bank, s_reg.faddr};
	assign exe_faddr = {s_reg.bank, s_reg.instr[FILE_AW-1:0]};
	assign sp_top = SP_W'(s_reg.sp - 1'b1);

	assign x.instr = s_reg.instr;
	assign x.acc = s_reg.acc;
	assign x.fval = s_reg.mem[exe_faddr];
	assign x.pc = s_reg.pc;
	assign x.pc_high_latch = s_reg.pc_high_latch;

	cccd_alu u_alu (
		.x(x)
	);

	always_comb
	begin
		logic [31:0] wd;
		logic [31:0] rv;
		logic do_write;
		wd = 32'h0;
		rv = 32'h0;
		// The write commits a cycle after both halves are held, so both orders work.
		do_write = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
		s_next = s_reg;
		s_next.div = tick ? DIV_LOAD : DIV_W'(s_reg.div - 1'b1);

		if (s_reg.awready && s_axi_awvalid)
		begin
			s_next.aw_hold = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_reg.wready && s_axi_wvalid)
		begin
			s_next.w_hold = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
		begin
			s_next.bvalid = 1'b0;
		end

		if (do_write)
		begin
			s_next.aw_hold = 1'b0;
			s_next.w_hold = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_reg.aw_addr)
				OFS_INSTR:
				begin
					wd = merge(32'h0, s_reg.w_data, s_reg.w_strb);
					// A new instruction while one is in flight is dropped.
					if (s_reg.state == ST_IDLE)
					begin
						s_next.instr = wd[13:0];
						s_next.state = ST_EXEC;
					end
				end
				OFS_ACC:
				begin
					wd = merge(32'(s_reg.acc), s_reg.w_data, s_reg.w_strb);
					s_next.acc = wd[7:0];
				end
				OFS_PC:
				begin
					wd = merge(32'(s_reg.pc), s_reg.w_data, s_reg.w_strb);
					s_next.pc = wd[14:0];
				end
				OFS_PC_HIGH_LATCH:
				begin
					wd = merge(32'(s_reg.pc_high_latch), s_reg.w_data, s_reg.w_strb);
					s_next.pc_high_latch = wd[6:0];
				end
				OFS_STATUS:
				begin
					wd = merge(32'h0, s_reg.w_data, s_reg.w_strb);
					if (s_reg.w_strb[0])
					begin
						s_next.z = wd[STAT_Z];
						if (wd[STAT_ILLEGAL])
						begin
							s_next.illegal = 1'b0;
						end
					end
				end
				OFS_BANK:
				begin
					wd = merge(32'(s_reg.bank), s_reg.w_data, s_reg.w_strb);
					s_next.bank = wd[BANK_W-1:0];
				end
				OFS_FADDR:
				begin
					wd = merge(32'(s_reg.faddr), s_reg.w_data, s_reg.w_strb);
					s_next.faddr = wd[6:0];
				end
				OFS_FDATA:
				begin
					wd = merge(32'(s_reg.mem[cur_faddr]), s_reg.w_data, s_reg.w_strb);
					s_next.mem[cur_faddr] = wd[7:0];
				end
				default:
				begin
				end
			endcase
		end

		if (s_reg.arready && s_axi_arvalid)
		begin
			unique case (s_axi_araddr)
				OFS_ACC: rv = 32'(s_reg.acc);
				OFS_PC: rv = 32'(s_reg.pc);
				OFS_PC_HIGH_LATCH: rv = 32'(s_reg.pc_high_latch);
				OFS_STATUS: rv = {28'h0, s_reg.illegal, s_reg.skip,
					s_reg.state != ST_IDLE, s_reg.z};
				OFS_BANK: rv = 32'(s_reg.bank);
				OFS_FADDR: rv = 32'(s_reg.faddr);
				OFS_FDATA: rv = 32'(s_reg.mem[cur_faddr]);
				OFS_RETURN_STACK_TOP: rv = 32'(s_reg.stack[sp_top]);
				OFS_STKPTR: rv = 32'(s_reg.sp);
				default: rv = 32'h0;
			endcase
			s_next.rvalid = 1'b1;
			s_next.rdata = rv;
			s_next.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_reg.rvalid && s_axi_rready)
		begin
			s_next.rvalid = 1'b0;
		end

		// Execution comes after the bus so that a hardware update wins over a
		// software write to the same register in the same cycle.
		unique case (s_reg.state)
			ST_IDLE:
			begin
			end
			ST_EXEC:
			begin
				if (tick)
				begin
					if (x.push)
					begin
						s_next.stack[s_reg.sp] = x.ret_addr;
						s_next.sp = SP_W'(s_reg.sp + 1'b1);
					end
					if (x.write_acc)
					begin
						s_next.acc = x.result;
					end
					if (x.write_file)
					begin
						s_next.mem[exe_faddr] = x.result;
					end
					if (x.z_update)
					begin
						s_next.z = x.z_value;
					end
					if (x.illegal)
					begin
						s_next.illegal = 1'b1;
					end
					s_next.pc = x.pc_next;
					s_next.skip = x.skip;
					s_next.state = x.two_cycle ? ST_SECOND : ST_IDLE;
				end
			end
			ST_SECOND:
			begin
				if (tick)
				begin
					// The discarded instruction still consumes its address.
					if (s_reg.skip)
					begin
						s_next.pc = 15'(s_reg.pc + 15'h0001);
					end
					s_next.skip = 1'b0;
					s_next.state = ST_IDLE;
				end
			end
		endcase

		s_next.awready = !s_next.aw_hold && !s_next.bvalid;
		s_next.wready = !s_next.w_hold && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg <= '0;
			s_reg.state <= ST_IDLE;
			s_reg.div <= DIV_LOAD;
			s_reg.acc <= ACC_RESET;
			s_reg.pc <= PC_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
endmodule

// file: bench/cccd_chk.sv
// Register-port checker for the call, zero, invert and decrement unit.
// Assumes it is bound to cccd_core and sees only that module's ports.
`timescale 1ns/1ns
module cccd_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	a_w_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && (s_axi_awaddr > 8'h24 || |s_axi_awaddr[1:0])
		|-> ##2 s_axi_bresp == 2'h2) else $error("unmapped write not refused");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready
		&& (s_axi_araddr > 8'h24 || |s_axi_araddr[1:0])
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the call, zero, invert and decrement unit over its register port.
// Assumes the package register map; the instruction cycle is one clock to keep the run short.
`timescale 1ns/1ns
module tb_top;
	import cccd_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rdat;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	logic [1:0] resp;
	int failures = 0, n_compared = 0, cycles = 0;
	logic [5:0] op_t [8] = '{OP_INVERT, OP_INVERT, OP_DEC, OP_DEC, OP_DEC_SKIP, OP_DEC_SKIP,
		OP_ZERO, OP_ZERO};
	logic d_t [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [7:0] in_t [8] = '{8'hff, 8'h5a, 8'h01, 8'h00, 8'h01, 8'h02, 8'h77, 8'h77};
	logic [7:0] res_t [8] = '{8'h00, 8'ha5, 8'h00, 8'hff, 8'h00, 8'h01, 8'h00, 8'h00};

	cccd_core #(.CYC_DIV(1)) i_cccd_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial forever #10 aclk = ~aclk;

	task automatic report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
		begin
			$display("ALL CHECKS OK");
		end
		else
		begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	// Address and data are released separately, each as soon as its own ready is seen.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit pa = 1;
		bit pw = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (pa || pw)
		begin
			@(posedge aclk);
			if (pa && s_axi_awready)
			begin
				pa = 0;
				s_axi_awvalid <= 0;
			end
			if (pw && s_axi_wready)
			begin
				pw = 0;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// With one clock per instruction cycle, the first read after the write answer lands in
	// the second cycle of a two-cycle operation; later polling only waits for idle.
	task automatic exec(input logic [13:0] ins, input logic two);
		wr(OFS_INSTR, {18'h0, ins});
		rd(OFS_STATUS);
		chk({31'h0, rdat[STAT_BUSY]}, {31'h0, two});
		for (int k = 0; k < 20; k++)
		begin
			rd(OFS_STATUS);
			if (rdat[STAT_BUSY] === 1'b0)
				break;
		end
		chk({31'h0, rdat[STAT_BUSY]}, 32'h0);
	endtask

	task automatic t_bus();
		rd(OFS_PC);
		chk(rdat, 32'h0);
		rd(OFS_INSTR);
		chk(rdat, 32'h0);
		rd(8'h28);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		chk(rdat, 32'h0);
		rd(8'h05);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(8'h28, 32'h1);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
	endtask

	task automatic t_call();
		wr(OFS_STATUS, 32'h1);
		wr(OFS_ACC, 32'h5a);
		wr(OFS_PC_HIGH_LATCH, 32'h3c);
		wr(OFS_PC, 32'h0123);
		exec({OP_CALL_ACC, 8'h00}, 1'b1);
		rd(OFS_PC);
		chk(rdat, {17'h0, 7'h3c, 8'h5a});
		rd(OFS_RETURN_STACK_TOP);
		chk(rdat, 32'h0124);
		rd(OFS_STKPTR);
		chk(rdat, 32'h1);
		rd(OFS_STATUS);
		chk({31'h0, rdat[STAT_Z]}, 32'h1);
	endtask

	// The zero flag is preset to the opposite of the expected result so a missed update shows.
	task automatic t_ops();
		logic zr;
		wr(OFS_BANK, 32'h3);
		wr(OFS_FADDR, 32'h45);
		for (int i = 0; i < 8; i++)
		begin
			zr = (res_t[i] == 8'h00);
			wr(OFS_FDATA, {24'h0, in_t[i]});
			wr(OFS_ACC, 32'h33);
			wr(OFS_PC, 32'h0100);
			wr(OFS_STATUS, {31'h0, !zr});
			exec({op_t[i], d_t[i], 7'h45}, op_t[i] == OP_DEC_SKIP && zr);
			rd(OFS_ACC);
			chk(rdat, {24'h0, d_t[i] ? 8'h33 : res_t[i]});
			rd(OFS_FDATA);
			chk(rdat, {24'h0, d_t[i] ? res_t[i] : in_t[i]});
			rd(OFS_STATUS);
			chk(rdat[STAT_Z], (op_t[i] == OP_DEC_SKIP) ? !zr : zr);
			rd(OFS_PC);
			chk(rdat, (op_t[i] == OP_DEC_SKIP && zr) ? 32'h0102 : 32'h0101);
		end
	endtask

	// An opcode outside the group only advances the counter and raises the sticky flag.
	task automatic t_illegal();
		wr(OFS_PC, 32'h0200);
		exec({6'h3f, 8'h00}, 1'b0);
		rd(OFS_STATUS);
		chk({31'h0, rdat[STAT_ILLEGAL]}, 32'h1);
		rd(OFS_PC);
		chk(rdat, 32'h0201);
		wr(OFS_STATUS, 32'h8);
		rd(OFS_STATUS);
		chk({31'h0, rdat[STAT_ILLEGAL]}, 32'h0);
	endtask

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_bus();
		t_call();
		t_ops();
		t_illegal();
		report_and_stop();
	end
endmodule

bind cccd_core cccd_chk i_cccd_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);
